/* smsp_port.sv */
`timescale 1ns/1ps
module smsp_port (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire smsp_pkg::smsp_cfg_t cfg,
  input wire logic [15:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic rx_read,
  output logic [15:0] rx_data,
  output logic [15:0] rx_shadow,
  input wire logic [2:0] err_clear,
  output smsp_pkg::smsp_status_t stat,
  input wire smsp_pkg::smsp_pin_in_t pins_in,
  output smsp_pkg::smsp_pin_out_t pins_out
);
  typedef struct packed {
    smsp_pkg::smsp_phase_t ph;
    logic [5:0] edge_cnt;
    logic [4:0] s_cnt;
    logic s_loaded;
    logic samp_due;
    logic pend;
    logic en_d;
    logic [15:0] tsh;
    logic [15:0] rsh;
    logic [15:0] last_tx;
    logic [15:0] rx_buf;
    logic [15:0] shadow;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic mosi_m;
    logic mosi_s;
    logic miso_m;
    logic miso_s;
    logic ss_m;
    logic ss_s;
    smsp_pkg::smsp_pin_out_t pins;
    smsp_pkg::smsp_status_t st;
  } smsp_core_state_t;

  smsp_core_state_t r_reg;
  smsp_core_state_t r_next;
  logic pop;
  logic word_done;
  logic lead;
  logic samp;
  logic tick;
  logic fifo_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_data;
  logic master_run;
  logic slave_run;
  logic [4:0] bits;
  logic [5:0] frame_edges;
  logic [7:1] sel_low;

  function automatic logic out_bit(input logic [15:0] sh, input logic lsb, input logic w16);
    out_bit = lsb ? sh[0] : (w16 ? sh[15] : sh[7]);
  endfunction

  function automatic logic [15:0] tx_step(input logic [15:0] sh, input logic lsb);
    tx_step = lsb ? {1'b0, sh[15:1]} : {sh[14:0], 1'b0};
  endfunction

  function automatic logic [15:0] rx_step(input logic [15:0] sh, input logic b, input logic lsb);
    rx_step = lsb ? {b, sh[15:1]} : {sh[14:0], b};
  endfunction

  function automatic logic [15:0] rx_word(input logic [15:0] sh, input logic lsb, input logic w16);
    rx_word = w16 ? sh : (lsb ? {8'h00, sh[15:8]} : {8'h00, sh[7:0]});
  endfunction

  // Transmit words wait here until a frame takes them
  smsp_fifo #(
    .WIDTH(smsp_pkg::DATA_W),
    .DEPTH(smsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(tx_valid),
    .in_ready(fifo_in_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Half-period pulses while a master frame runs
  smsp_baud u_baud (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(r_reg.ph != smsp_pkg::PH_IDLE),
    .baud(cfg.baud),
    .tick(tick)
  );

  assign master_run = cfg.master_select_bit & cfg.port_enable_bit;
  assign slave_run = ~cfg.master_select_bit & cfg.port_enable_bit;
  assign bits = cfg.word_long_bit ? smsp_pkg::BITS_LONG : smsp_pkg::BITS_SHORT;
  assign frame_edges = cfg.word_long_bit ? smsp_pkg::EDGES_LONG : smsp_pkg::EDGES_SHORT;

  // Per-select drive: software level in phase one, frame window in phase zero
  for (genvar i = 1; i <= smsp_pkg::NSEL; i++) begin : g_sel
    assign sel_low[i] = master_run & cfg.select_output_enable[i] &
      (cfg.clock_phase_bit ? ~cfg.select_output_value[i] :
      (r_reg.ph != smsp_pkg::PH_IDLE));
  end

  // Next-state logic for both roles
  always_comb begin
    r_next = r_reg;
    pop = 1'b0;
    word_done = 1'b0;
    lead = 1'b0;
    samp = 1'b0;
    r_next.st.done_pulse = 1'b0;
    r_next.st.transmit_full_flag = ~fifo_in_ready;
    r_next.sck_m = pins_in.sck_i;
    r_next.sck_s = r_reg.sck_m;
    r_next.sck_d = r_reg.sck_s;
    r_next.mosi_m = pins_in.mosi_i;
    r_next.mosi_s = r_reg.mosi_m;
    r_next.miso_m = pins_in.miso_i;
    r_next.miso_s = r_reg.miso_m;
    r_next.ss_m = pins_in.slave_select_input_n;
    r_next.ss_s = r_reg.ss_m;
    r_next.en_d = cfg.port_enable_bit;
    // Clears come first so that a same-cycle set wins
    if (rx_read) begin
      r_next.st.receive_full_flag = 1'b0;
    end
    if (err_clear[0]) begin
      r_next.st.underrun_flag = 1'b0;
    end
    if (err_clear[1]) begin
      r_next.st.overflow_flag = 1'b0;
    end
    if (err_clear[2]) begin
      r_next.st.mode_fault_flag = 1'b0;
    end
    // Start requests
    if (cfg.transfer_initiation_mode == smsp_pkg::START_ON_READ && rx_read) begin
      r_next.pend = 1'b1;
    end
    if (cfg.transfer_initiation_mode == smsp_pkg::START_ON_WRITE &&
        ((cfg.port_enable_bit & ~r_reg.en_d) | (tx_valid & fifo_in_ready))) begin
      r_next.pend = 1'b1;
    end
    if (master_run) begin
      r_next.s_cnt = 5'h00;
      r_next.s_loaded = 1'b0;
      if (!r_reg.ss_s) begin
        // Another master pulls our select: stop and flag
        r_next.st.mode_fault_flag = 1'b1;
        r_next.ph = smsp_pkg::PH_IDLE;
        r_next.pend = 1'b0;
        r_next.pins.sck_o = cfg.clock_polarity_bit;
      end else begin
        unique case (r_reg.ph)
          smsp_pkg::PH_IDLE: begin
            r_next.pins.sck_o = cfg.clock_polarity_bit;
            if (r_reg.pend) begin
              r_next.pend = 1'b0;
              r_next.st.transfer_finished_flag = 1'b0;
              r_next.edge_cnt = 6'h00;
              r_next.samp_due = 1'b0;
              r_next.ph = smsp_pkg::PH_LEAD;
              if (fifo_valid) begin
                pop = 1'b1;
                r_next.tsh = fifo_data;
                r_next.last_tx = fifo_data;
              end else begin
                r_next.tsh = r_reg.last_tx;
                r_next.st.underrun_flag = 1'b1;
              end
            end
          end
          smsp_pkg::PH_LEAD: begin
            if (tick) begin
              r_next.ph = smsp_pkg::PH_SHIFT;
            end
          end
          smsp_pkg::PH_SHIFT: begin
            if (tick) begin
              r_next.pins.sck_o = ~r_reg.pins.sck_o;
              r_next.edge_cnt = r_reg.edge_cnt + 6'h01;
              lead = ~r_reg.edge_cnt[0];
              samp = lead ^ cfg.clock_phase_bit;
              // Capture one half period late so the synced input has settled
              r_next.samp_due = samp;
              if (r_reg.samp_due) begin
                r_next.rsh = rx_step(r_reg.rsh, r_reg.miso_s, cfg.lsb_first_bit);
              end
              if (!samp && r_reg.edge_cnt != 6'h00) begin
                r_next.tsh = tx_step(r_reg.tsh, cfg.lsb_first_bit);
              end
              if (r_next.edge_cnt == frame_edges) begin
                r_next.ph = smsp_pkg::PH_TAIL;
              end
            end
          end
          smsp_pkg::PH_TAIL: begin
            if (tick) begin
              r_next.ph = smsp_pkg::PH_IDLE;
              r_next.samp_due = 1'b0;
              if (r_reg.samp_due) begin
                r_next.rsh = rx_step(r_reg.rsh, r_reg.miso_s, cfg.lsb_first_bit);
              end
              word_done = 1'b1;
            end
          end
        endcase
      end
    end else begin
      r_next.ph = smsp_pkg::PH_IDLE;
      r_next.pend = 1'b0;
      r_next.pins.sck_o = cfg.clock_polarity_bit;
      if (slave_run && !r_reg.ss_s) begin
        if (!r_reg.s_loaded) begin
          r_next.s_loaded = 1'b1;
          r_next.s_cnt = 5'h00;
          if (fifo_valid) begin
            pop = 1'b1;
            r_next.tsh = fifo_data;
            r_next.last_tx = fifo_data;
          end else begin
            r_next.tsh = r_reg.last_tx;
            r_next.st.underrun_flag = 1'b1;
          end
        end else if (r_reg.sck_s != r_reg.sck_d) begin
          lead = (r_reg.sck_s != cfg.clock_polarity_bit);
          samp = lead ^ cfg.clock_phase_bit;
          if (samp) begin
            r_next.rsh = rx_step(r_reg.rsh, r_reg.mosi_s, cfg.lsb_first_bit);
            r_next.s_cnt = r_reg.s_cnt + 5'h01;
            if (r_next.s_cnt == bits) begin
              word_done = 1'b1;
              r_next.s_loaded = 1'b0;
            end
          end else if (r_reg.s_cnt != 5'h00) begin
            r_next.tsh = tx_step(r_reg.tsh, cfg.lsb_first_bit);
          end
        end
      end else begin
        r_next.s_cnt = 5'h00;
      end
    end
    // A finished word lands in the shadow and, if room, the receive buffer
    if (word_done) begin
      r_next.shadow = rx_word(r_next.rsh, cfg.lsb_first_bit, cfg.word_long_bit);
      if (r_next.st.receive_full_flag) begin
        r_next.st.overflow_flag = 1'b1;
      end else begin
        r_next.rx_buf = rx_word(r_next.rsh, cfg.lsb_first_bit, cfg.word_long_bit);
      end
      r_next.st.receive_full_flag = 1'b1;
      r_next.st.transfer_finished_flag = 1'b1;
      r_next.st.done_pulse = 1'b1;
    end
    // Pin drive; data and selects only ever pull low
    r_next.pins.sck_oe_n = ~master_run;
    r_next.pins.mosi_o = 1'b0;
    r_next.pins.miso_o = 1'b0;
    r_next.pins.sel_o = 7'h00;
    r_next.pins.mosi_oe_n = ~(master_run && r_next.ph != smsp_pkg::PH_IDLE &&
      !out_bit(r_next.tsh, cfg.lsb_first_bit, cfg.word_long_bit));
    r_next.pins.miso_oe_n = ~(slave_run && !r_reg.ss_s && r_next.s_loaded &&
      !out_bit(r_next.tsh, cfg.lsb_first_bit, cfg.word_long_bit));
    r_next.pins.sel_oe_n = ~sel_low;
  end

  // State register; selects and data released under reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.ph <= smsp_pkg::PH_IDLE;
      r_reg.ss_m <= 1'b1;
      r_reg.ss_s <= 1'b1;
      r_reg.pins.sck_oe_n <= 1'b1;
      r_reg.pins.mosi_oe_n <= 1'b1;
      r_reg.pins.miso_oe_n <= 1'b1;
      r_reg.pins.sel_oe_n <= smsp_pkg::SEL_RELEASED;
      r_reg.last_tx <= smsp_pkg::DATA_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tx_ready = fifo_in_ready;
  assign rx_data = r_reg.rx_buf;
  assign rx_shadow = r_reg.shadow;
  assign stat = r_reg.st;
  assign pins_out = r_reg.pins;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Checks on the running port
  sel_release_a: assert property (!cfg.master_select_bit |=> &pins_out.sel_oe_n)
    else $error("select driven outside master mode");
  sel_soft_a: assert property (master_run && cfg.clock_phase_bit && cfg.select_output_enable[1]
    |=> pins_out.sel_oe_n[1] == $past(cfg.select_output_value[1]))
    else $error("select one does not follow its value bit");
  sel_hw_a: assert property (master_run && !cfg.clock_phase_bit && cfg.select_output_enable[1]
    && r_reg.ph == smsp_pkg::PH_IDLE |=> pins_out.sel_oe_n[1])
    else $error("select held between words in phase zero");
  sck_rate_a: assert property (master_run && r_reg.ph == smsp_pkg::PH_SHIFT
    && $changed(pins_out.sck_o) |=> $stable(pins_out.sck_o))
    else $error("serial clock faster than a quarter of the system clock");
  sck_idle_a: assert property (master_run && r_reg.ph == smsp_pkg::PH_IDLE
    && $past(r_reg.ph) == smsp_pkg::PH_IDLE && $stable(cfg.clock_polarity_bit)
    && $past(master_run) |-> pins_out.sck_o == cfg.clock_polarity_bit)
    else $error("serial clock not at idle level between frames");
  frame_edges_a: assert property ($rose(r_reg.ph == smsp_pkg::PH_TAIL) && $stable(cfg.word_long_bit)
    |-> r_reg.edge_cnt == frame_edges)
    else $error("frame edge count differs from word length");
  fin_set_a: assert property (r_reg.ph == smsp_pkg::PH_TAIL && tick && master_run && r_reg.ss_s
    |=> stat.transfer_finished_flag && stat.done_pulse && stat.receive_full_flag)
    else $error("finished flag missing after last edge");
  rxs_hold_a: assert property (stat.receive_full_flag && !rx_read |=> stat.receive_full_flag)
    else $error("receive full cleared without a buffer read");
  slave_quiet_a: assert property (slave_run && r_reg.ss_s |=> pins_out.miso_oe_n)
    else $error("slave drives data while unselected");
  fault_flag_a: assert property (master_run && !r_reg.ss_s
    |=> stat.mode_fault_flag && r_reg.ph == smsp_pkg::PH_IDLE)
    else $error("conflict not flagged");

  master_word_c: cover property (master_run && stat.done_pulse);
  slave_word_c: cover property (slave_run && stat.done_pulse);
  overflow_c: cover property ($rose(stat.overflow_flag));
  fault_c: cover property ($rose(stat.mode_fault_flag));
endmodule

/* smsp_pkg.sv */
package smsp_pkg;

  // Data path and select widths, transmit buffer depth
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int NSEL = 7;

  // Word lengths and the clock edges that one frame holds
  localparam logic [4:0] BITS_SHORT = 5'h08;
  localparam logic [4:0] BITS_LONG = 5'h10;
  localparam logic [5:0] EDGES_SHORT = 6'h10;
  localparam logic [5:0] EDGES_LONG = 6'h20;

  // System clock and serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [15:0] HALF_MIN = 16'h0002;

  // Transfer initiation modes
  localparam logic [1:0] START_ON_READ = 2'h0;
  localparam logic [1:0] START_ON_WRITE = 2'h1;

  // Reset values
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:1] SEL_RELEASED = 7'h7f;

  // Static configuration seen by the port
  typedef struct packed {
    logic master_select_bit;
    logic port_enable_bit;
    logic clock_phase_bit;
    logic clock_polarity_bit;
    logic word_long_bit;
    logic lsb_first_bit;
    logic [1:0] transfer_initiation_mode;
    logic [15:0] baud;
    logic [7:1] select_output_enable;
    logic [7:1] select_output_value;
  } smsp_cfg_t;

  // Status flags
  typedef struct packed {
    logic transfer_finished_flag;
    logic receive_full_flag;
    logic transmit_full_flag;
    logic underrun_flag;
    logic overflow_flag;
    logic mode_fault_flag;
    logic done_pulse;
  } smsp_status_t;

  // Pin levels arriving from the board
  typedef struct packed {
    logic sck_i;
    logic mosi_i;
    logic miso_i;
    logic slave_select_input_n;
  } smsp_pin_in_t;

  // Pin drive: output value plus active-low enable
  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic [7:1] sel_o;
    logic [7:1] sel_oe_n;
  } smsp_pin_out_t;

  typedef enum logic [1:0] {PH_IDLE, PH_LEAD, PH_SHIFT, PH_TAIL} smsp_phase_t;

endpackage

/* smsp_fifo.sv */
`timescale 1ns/1ps
module smsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } smsp_fifo_state_t;

  smsp_fifo_state_t r_reg;
  smsp_fifo_state_t r_next;
  logic push;
  logic pop;

  // Push and pop with registered full and empty
  always_comb begin
    r_next = r_reg;
    push = in_valid & ~r_reg.full;
    pop = out_ready & ~r_reg.empty;
    if (push) begin
      r_next.mem[r_reg.wr] = in_data;
      r_next.wr = (r_reg.wr == AW'(DEPTH - 1)) ? '0 : r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = (r_reg.rd == AW'(DEPTH - 1)) ? '0 : r_reg.rd + 1'b1;
    end
    r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    r_next.full = (r_next.cnt == (AW+1)'(DEPTH));
    r_next.empty = (r_next.cnt == '0);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.empty <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready = ~r_reg.full;
  assign out_valid = ~r_reg.empty;
  assign out_data = r_reg.mem[r_reg.rd];
endmodule

/* smsp_baud.sv */
`timescale 1ns/1ps
module smsp_baud (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [15:0] baud,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } smsp_baud_state_t;

  smsp_baud_state_t r_reg;
  smsp_baud_state_t r_next;
  logic [15:0] half;

  // One pulse per half serial period, never shorter than the floor
  always_comb begin
    half = (baud < smsp_pkg::HALF_MIN) ? smsp_pkg::HALF_MIN : baud;
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (!run) begin
      r_next.cnt = 16'h0000;
    end else if (r_reg.cnt >= half - 16'h0001) begin
      r_next.cnt = 16'h0000;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;
endmodule

/* smsp_slave_model.sv */
`timescale 1ns/1ps
// Far-end slave: open-drain data out, samples and shifts per the shared mode
module smsp_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire smsp_pkg::smsp_cfg_t cfg,
  input wire logic [15:0] tx_word,
  output logic miso_low,
  output logic [15:0] rx_word,
  output int words
);
  int cnt;
  logic [15:0] sh;
  logic [4:0] w;

  // Bit that goes out n-th in the chosen order
  function automatic logic nth(input int n);
    return cfg.lsb_first_bit ? tx_word[n] : tx_word[w - 1 - n];
  endfunction

  // Word length follows the master's setting
  assign w = cfg.word_long_bit ? 5'h10 : 5'h08;

  // Start state
  initial begin
    miso_low = 1'b0;
    rx_word = 16'h0000;
    words = 0;
    cnt = 0;
    sh = 16'h0000;
  end

  // Select edge restarts the word; released select lets the line float up
  always @(sel_n) begin
    cnt = 0;
    sh = 16'h0000;
    miso_low = !sel_n && !cfg.clock_phase_bit && !nth(0);
  end

  // Sample on one edge kind and shift on the other
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != cfg.clock_polarity_bit) ^ cfg.clock_phase_bit) begin
        sh[cfg.lsb_first_bit ? cnt : w - 1 - cnt] = mosi;
        cnt++;
        if (cnt == w) begin
          rx_word = sh;
          words++;
          cnt = 0;
          sh = 16'h0000;
        end
      end else if (cfg.clock_phase_bit || cnt != 0) begin
        miso_low = !nth(cnt);
      end
    end
  end
endmodule

/* smsp_port_bench.sv */
`timescale 1ns/1ps
module smsp_port_bench;
  typedef struct packed {
    logic [3:0] m;
    logic [15:0] baud;
    logic [15:0] mo;
    logic [15:0] so;
  } smsp_row_t;

  // Mode bits are polarity, phase, long word, lsb first
  localparam smsp_row_t ROWS [6] = '{
    '{4'h0, 16'h0003, 16'hff5a, 16'h003c},
    '{4'h5, 16'h0004, 16'h0081, 16'h00e7},
    '{4'ha, 16'h0004, 16'hc3a5, 16'h5a0f},
    '{4'hf, 16'h0005, 16'h8001, 16'h7ffe},
    '{4'h3, 16'h0000, 16'h1234, 16'h4321},
    '{4'hc, 16'h0003, 16'h00f0, 16'h000f}};

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  smsp_pkg::smsp_cfg_t cfg;
  logic [15:0] tx_data, rx_data, rx_shadow, s_tx, s_rx;
  logic tx_valid, tx_ready, rx_read, s_low, sck_q;
  logic [7:0] sg;
  logic [2:0] err_clear;
  smsp_pkg::smsp_status_t stat;
  smsp_pkg::smsp_pin_in_t pins_in;
  smsp_pkg::smsp_pin_out_t pins_out;
  logic b_sck = 1'b0;
  logic b_mosi = 1'b1;
  logic b_ss_n = 1'b1;
  logic sck_l, mosi_l, miso_l, sel_l;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int edges = 0;
  int gap = 0;
  int s_words, k, h, wd;
  smsp_row_t r;

  // Board lines: open drain with pull-ups, clock pushed by the master
  assign sck_l = pins_out.sck_oe_n ? b_sck : pins_out.sck_o;
  assign mosi_l = b_mosi & (pins_out.mosi_oe_n | pins_out.mosi_o);
  assign miso_l = !s_low & (pins_out.miso_oe_n | pins_out.miso_o);
  assign sel_l = pins_out.sel_oe_n[1] | pins_out.sel_o[1];
  assign pins_in = {sck_l, mosi_l, miso_l, b_ss_n};

  smsp_port u_smsp_port (.ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_read(rx_read), .rx_data(rx_data),
    .rx_shadow(rx_shadow), .err_clear(err_clear), .stat(stat), .pins_in(pins_in),
    .pins_out(pins_out));
  smsp_slave_model u_smsp_slave_model (.sck(sck_l), .mosi(mosi_l), .sel_n(sel_l), .cfg(cfg),
    .tx_word(s_tx), .miso_low(s_low), .rx_word(s_rx), .words(s_words));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cycle count, timeout, serial clock edge count and spacing
  always @(posedge ref_clk) begin
    cyc++;
    gap++;
    if (sck_l !== sck_q) begin
      if (gap < 2 && !pins_out.sck_oe_n) chk(gap, 2);
      edges++;
      gap = 0;
    end
    sck_q = sck_l;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic push(input logic [15:0] d);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge ref_clk);
    tx_valid <= 1'b0;
  endtask

  task automatic rd();
    rx_read <= 1'b1;
    @(posedge ref_clk);
    rx_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 3000 && stat.done_pulse !== 1'b1; i++) @(posedge ref_clk);
    chk(stat.done_pulse, 1'b1);
  endtask

  task automatic clear(input logic [2:0] c);
    err_clear <= c;
    tick(1);
    err_clear <= 3'h0;
    tick(2);
  endtask

  // Slave-side bit banging of one 8-bit word, mode 0; reply read before each rising edge
  // Half period of 6 cycles leaves room for the port's synced reply
  task automatic bang(input logic [7:0] pat, output logic [7:0] got);
    int j;
    got = 8'h00;
    b_mosi <= pat[7];
    tick(4);
    for (j = 0; j < 16; j++) begin
      if (j % 2 == 0) got = {got[6:0], miso_l};
      b_sck <= ~b_sck;
      if (j % 2 == 1 && j < 15) b_mosi <= pat[6 - j / 2];
      tick(6);
    end
    b_mosi <= 1'b1;
    tick(8);
  endtask

  // Main sequence
  initial begin
    cfg = '0;
    tx_data = 16'h0000;
    tx_valid = 1'b0;
    rx_read = 1'b0;
    err_clear = 3'h0;
    s_tx = 16'h0000;
    sck_q = 1'b0;
    tick(11);
    chk(pins_out.sel_oe_n, 7'h7f);
    chk({pins_out.mosi_oe_n, pins_out.miso_oe_n}, 2'h3);
    chk(stat, 7'h00);
    tick(1);
    nrst <= 1'b1;
    tick(2);
    $display("test reset done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      h = (r.baud < 2) ? 2 : r.baud;
      wd = r.m[1] ? 16 : 8;
      cfg <= '{1'b1, 1'b1, r.m[2], r.m[3], r.m[1], r.m[0], 2'h0, r.baud, 7'h00,
        {6'h3f, ~r.m[2]}};
      tick(3);
      cfg.select_output_enable <= 7'h01;
      s_tx <= r.so;
      tick(3);
      push(r.mo);
      tick(3);
      edges = 0;
      rd();
      chk(stat.receive_full_flag, 1'b0);
      wait_done();
      chk(gap >= h - 1 && gap <= h + 2, 1'b1);
      tick(h + 4);
      chk(edges, 2 * wd);
      chk(sck_l, r.m[3]);
      chk(sel_l, !r.m[2]);
      chk(s_rx, wd == 8 ? {8'h00, r.mo[7:0]} : r.mo);
      chk(rx_data, wd == 8 ? {8'h00, r.so[7:0]} : r.so);
      chk({stat.receive_full_flag, stat.transfer_finished_flag}, 2'h3);
      $display("test row %0d done", i);
    end
    cfg <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 16'h0004, 7'h0f, 7'h05};
    tick(4);
    chk(pins_out.sel_oe_n, 7'h75);
    chk({pins_out.sel_o, pins_out.sck_oe_n}, 8'h00);
    $display("test selects done");
    cfg <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 16'h0004, 7'h01, 7'h7f};
    s_tx <= 16'h0099;
    push(16'h0011);
    tick(4);
    k = s_words;
    cfg.port_enable_bit <= 1'b1;
    wait_done();
    tick(8);
    chk(stat.overflow_flag, 1'b1);
    chk({rx_data, rx_shadow}, 32'h000f0099);
    chk(stat.receive_full_flag, 1'b1);
    push(16'h0022);
    wait_done();
    tick(8);
    chk(s_rx, 16'h0022);
    chk(s_words, k + 2);
    cfg.transfer_initiation_mode <= 2'h0;
    tick(2);
    rd();
    wait_done();
    tick(8);
    chk({stat.underrun_flag, s_rx}, 17'h10022);
    clear(3'h3);
    chk({stat.underrun_flag, stat.overflow_flag}, 2'h0);
    b_ss_n <= 1'b0;
    tick(6);
    chk(stat.mode_fault_flag, 1'b1);
    b_ss_n <= 1'b1;
    tick(4);
    clear(3'h4);
    chk(stat.mode_fault_flag, 1'b0);
    $display("test flags done");
    cfg.transfer_initiation_mode <= 2'h2;
    tx_valid <= 1'b1;
    for (k = 0; k < 5; k++) begin
      tx_data <= 16'h00a0 + 16'(k);
      @(posedge ref_clk);
    end
    tick(2);
    chk({tx_ready, stat.transmit_full_flag}, 2'h1);
    tx_valid <= 1'b0;
    cfg.transfer_initiation_mode <= 2'h0;
    for (k = 0; k < 4; k++) begin
      rd();
      wait_done();
      tick(6);
      chk(s_rx, 16'h00a0 + 16'(k));
    end
    chk({tx_ready, stat.transmit_full_flag}, 2'h2);
    $display("test buffer done");
    cfg <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0004, 7'h00, 7'h7f};
    tick(4);
    chk(pins_out.sck_oe_n, 1'b1);
    rd();
    tick(2);
    chk(stat.receive_full_flag, 1'b0);
    bang(8'h5a, sg);
    chk(stat.receive_full_flag, 1'b0);
    chk(sg, 8'hff);
    b_ss_n <= 1'b0;
    bang(8'ha5, sg);
    b_ss_n <= 1'b1;
    chk(sg, 8'ha3);
    chk({stat.receive_full_flag, rx_data}, 17'h100a5);
    $display("test slave done");
    final_report();
  end
endmodule
